// ==== hdl/adcsq_regs.sv ====
// converter control, successive-approximation sequencer and register file on AXI4-Lite
//
// Functional notes
// - each conversion yields one 10-bit result from the selected input
// - alignment 0: high=D9..D2, low[7:6]=D1:D0; alignment 1: low=D7..D0, high[1:0]=D9:D8
// - result bits not carrying data read as zero
// - results stay untouched while the converter is disabled
// - control zero holds start bit and read-only busy flag; busy writes ignored
// - channel code 0000 is channel 0, 0010..0110 channels 2..6; 0001, 0111 reserved
// - source field in control one picks internal signal, ground or selected external channel
// - pin assigned to converter loses its other function and its pull-high
// - one conversion engine, at most one source multiplexed onto it at a time; none routed while disabled or for external channel codes 0001, 0111 up
// - bandgap enable bit switches the bandgap reference on
// - start bit written 0 then 1 then 0 begins a conversion
// - source 100 internal, 000 and 101..111 external, 001..011 ground
// - conversion clock is system clock divided by 2 to the power of the code
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "adcsq_defs.svh"
module adcsq_regs
    import adcsq_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [6:0] pin_analog_assign,
    input wire logic comparator_in,
    output logic [6:0] pin_function_disconnect,
    output logic [6:0] pull_high_disable,
    output adcsq_input_sel_type input_sel,
    output logic [9:0] dac_code,
    output logic sample_hold,
    output logic converter_power,
    output logic bandgap_enable,
    output logic [1:0] reference_voltage_select,
    output logic irq
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0] ctrl_zero;
    logic [7:0] ctrl_one;
    logic [9:0] result;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    adcsq_state_type state;
    logic [9:0] trial;
    logic [3:0] bit_index;
    logic [6:0] prescale;
    logic cmp_meta;
    logic cmp_sync;
    logic [ADDR_W-1:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic w_strb0;
    logic w_held;

    wire start_bit = ctrl_zero[`ADCSQ_BIT_START];
    wire converter_enable = ctrl_zero[`ADCSQ_BIT_ENABLE];
    wire result_alignment_select = ctrl_zero[`ADCSQ_BIT_ALIGN];
    wire [3:0] external_channel_select = ctrl_zero[3:0];
    wire [2:0] input_source_select = ctrl_one[7:5];
    wire [1:0] ref_select_field = ctrl_one[4:3];
    wire [2:0] conversion_clock_divider = ctrl_one[2:0];
    wire conversion_busy_flag = (state != ST_IDLE);

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_en = do_write && w_strb0;
    wire wr_ctrl_zero = wr_en && (aw_addr == `ADCSQ_OFS_CTRL_ZERO);
    wire wr_ctrl_one = wr_en && (aw_addr == `ADCSQ_OFS_CTRL_ONE);
    wire wr_bandgap = wr_en && (aw_addr == `ADCSQ_OFS_BANDGAP);
    wire wr_irq_clear = wr_en && (aw_addr == `ADCSQ_OFS_IRQ_CLEAR);
    wire wr_irq_enable = wr_en && (aw_addr == `ADCSQ_OFS_IRQ_ENABLE);
    wire wr_mapped = (aw_addr == `ADCSQ_OFS_RESULT_LOW) || (aw_addr == `ADCSQ_OFS_RESULT_HIGH)
        || (aw_addr == `ADCSQ_OFS_CTRL_ZERO) || (aw_addr == `ADCSQ_OFS_CTRL_ONE)
        || (aw_addr == `ADCSQ_OFS_BANDGAP) || (aw_addr == `ADCSQ_OFS_IRQ_STATUS)
        || (aw_addr == `ADCSQ_OFS_IRQ_CLEAR) || (aw_addr == `ADCSQ_OFS_IRQ_ENABLE);
    // busy bit of the written byte is dropped: busy only follows the sequencer
    wire [7:0] next_ctrl_zero = {w_data[7], 1'b0, w_data[5:0]};
    // completed 0-1-0 pulse: stored start is 1 and the new write clears it
    wire start_pulse = wr_ctrl_zero && start_bit && !w_data[`ADCSQ_BIT_START];

    // ----------------------------------------------------------------
    // result views
    // ----------------------------------------------------------------
    wire [7:0] result_low_byte = result_alignment_select ? result[7:0]
        : {result[1:0], 6'h00};
    wire [7:0] result_high_byte = result_alignment_select ? {6'h00, result[9:8]}
        : result[9:2];

    logic [7:0] read_byte;
    logic read_hit;
    always_comb begin
        read_hit = 1'b1;
        case (s_axi_araddr)
            `ADCSQ_OFS_RESULT_LOW: read_byte = result_low_byte;
            `ADCSQ_OFS_RESULT_HIGH: read_byte = result_high_byte;
            `ADCSQ_OFS_CTRL_ZERO: read_byte = {ctrl_zero[7], conversion_busy_flag, ctrl_zero[5:0]};
            `ADCSQ_OFS_CTRL_ONE: read_byte = ctrl_one;
            `ADCSQ_OFS_BANDGAP: read_byte = {4'h0, bandgap_enable, 3'h0};
            `ADCSQ_OFS_IRQ_STATUS: read_byte = {6'h00, irq_status};
            `ADCSQ_OFS_IRQ_CLEAR: read_byte = 8'h00;
            `ADCSQ_OFS_IRQ_ENABLE: read_byte = {6'h00, irq_enable};
            default: begin
                read_byte = 8'h00;
                read_hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // input routing
    // ----------------------------------------------------------------
    wire src_internal = (input_source_select == `ADCSQ_SRC_INTERNAL);
    wire src_ground = (input_source_select != 3'h0) && (input_source_select < `ADCSQ_SRC_INTERNAL);
    wire src_external = !src_internal && !src_ground;
    adcsq_input_sel_type next_sel;
    assign next_sel.internal = converter_enable && src_internal;
    assign next_sel.ground = converter_enable && src_ground;
    genvar ch;
    generate
        for (ch = 0; ch < 7; ch++) begin : g_channel
            // codes 0001 and 0111 upward route nothing
            assign next_sel.ext_channel[ch] = converter_enable && src_external
                && (external_channel_select == 4'(ch)) && (ch != 1);
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_function_disconnect[ch] <= 1'b0;
                    pull_high_disable[ch] <= 1'b0;
                end else if (clk_en) begin
                    pin_function_disconnect[ch] <= pin_analog_assign[ch];
                    pull_high_disable[ch] <= pin_analog_assign[ch];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // conversion clock and sequencer
    // ----------------------------------------------------------------
    wire [6:0] prescale_limit = 7'((8'h01 << conversion_clock_divider) - 8'h01);
    wire conv_tick = (prescale == prescale_limit);
    wire abort = conversion_busy_flag && !converter_enable;
    wire begin_conv = (state == ST_IDLE) && start_pulse && w_data[`ADCSQ_BIT_ENABLE];
    wire sar_step = (state == ST_CONVERT) && conv_tick && converter_enable;
    wire [9:0] decided = cmp_sync ? trial : (trial & ~(10'h001 << bit_index));
    wire finish = sar_step && (bit_index == 4'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else if (clk_en) begin
            cmp_meta <= comparator_in;
            cmp_sync <= cmp_meta;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            prescale <= 7'h00;
            trial <= 10'h000;
            bit_index <= 4'h0;
        end else if (clk_en) begin
            prescale <= (conv_tick || state == ST_IDLE) ? 7'h00 : prescale + 7'h01;
            case (state)
                ST_IDLE: begin
                    if (begin_conv) begin
                        state <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (abort) begin
                        state <= ST_IDLE;
                    end else if (conv_tick) begin
                        state <= ST_CONVERT;
                        trial <= `ADCSQ_SAR_MSB;
                        bit_index <= `ADCSQ_SAR_TOP_INDEX;
                    end
                end
                ST_CONVERT: begin
                    if (abort) begin
                        state <= ST_IDLE;
                    end else if (finish) begin
                        state <= ST_IDLE;
                        trial <= decided;
                    end else if (sar_step) begin
                        trial <= decided | (10'h001 << (bit_index - 4'h1));
                        bit_index <= bit_index - 4'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_zero <= `ADCSQ_RST_CTRL_ZERO;
            ctrl_one <= `ADCSQ_RST_CTRL_ONE;
            bandgap_enable <= `ADCSQ_RST_BANDGAP;
            result <= `ADCSQ_RST_RESULT;
            irq_status <= `ADCSQ_RST_IRQ;
            irq_enable <= `ADCSQ_RST_IRQ;
        end else if (clk_en) begin
            if (wr_ctrl_zero) begin
                ctrl_zero <= next_ctrl_zero;
            end
            if (wr_ctrl_one) begin
                ctrl_one <= w_data[7:0];
            end
            if (wr_bandgap) begin
                bandgap_enable <= w_data[`ADCSQ_BIT_BANDGAP];
            end
            if (finish && converter_enable) begin
                result <= decided;
            end
            if (wr_irq_enable) begin
                irq_enable <= w_data[1:0];
            end
            // hardware set wins over a clear in the same cycle
            irq_status <= (wr_irq_clear ? (irq_status & ~w_data[1:0]) : irq_status)
                | {abort, finish};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            input_sel <= '0;
            dac_code <= 10'h000;
            sample_hold <= 1'b0;
            converter_power <= 1'b0;
            reference_voltage_select <= 2'h0;
            irq <= 1'b0;
        end else if (clk_en) begin
            input_sel <= next_sel;
            dac_code <= trial;
            sample_hold <= (state == ST_SAMPLE);
            converter_power <= converter_enable;
            reference_voltage_select <= ref_select_field;
            irq <= |(irq_status & irq_enable);
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite handshakes
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCSQ_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb0 <= 1'b0;
        end else if (clk_en) begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ADCSQ_RESP_OKAY;
        end else if (clk_en) begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, read_byte};
                s_axi_rresp <= read_hit ? `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_start_busy: assert property (clk_en && begin_conv |=> conversion_busy_flag)
        else $error("start pulse did not raise busy");
    chk_abort_path: assert property (clk_en && abort |=> !conversion_busy_flag ##0 $stable(result))
        else $error("abort did not clear busy or changed result");
    chk_result_hold: assert property (!converter_enable |=> $stable(result))
        else $error("result changed while disabled");
    chk_finish_store: assert property (clk_en && finish && converter_enable |=>
        result == $past(decided) && !conversion_busy_flag)
        else $error("finish did not store result and clear busy");
    chk_align_zero: assert property ((result_alignment_select ? result_high_byte[7:2]
        : result_low_byte[5:0]) == 6'h00)
        else $error("unused result bits not zero");
    chk_align_map: assert property (!result_alignment_select |->
        {result_high_byte, result_low_byte[7:6]} == result)
        else $error("left alignment mapping wrong");
    chk_one_source: assert property ($onehot0(input_sel))
        else $error("more than one source routed");
    chk_internal_route: assert property (clk_en && converter_enable && src_internal
        |=> input_sel.internal && input_sel.ext_channel == 7'h00)
        else $error("internal source not routed alone");
    chk_div_spacing: assert property (clk_en && conv_tick && state == ST_CONVERT
        && conversion_clock_divider != 3'h0 && !wr_ctrl_one |=> !conv_tick)
        else $error("divided tick came too early");
    chk_pin_release: assert property (clk_en |=> pull_high_disable == $past(pin_analog_assign))
        else $error("pull-high not released for analog pin");
    chk_busy_ignored: assert property (clk_en && wr_ctrl_zero && !begin_conv
        && state == ST_IDLE |=> !conversion_busy_flag)
        else $error("busy bit took a write");
endmodule
`default_nettype wire

// ==== hdl/adcsq_defs.svh ====
// register offsets, field positions, reset values and counts of the converter block
`ifndef ADCSQ_DEFS_SVH
`define ADCSQ_DEFS_SVH
`define ADCSQ_OFS_RESULT_LOW 8'h00
`define ADCSQ_OFS_RESULT_HIGH 8'h04
`define ADCSQ_OFS_CTRL_ZERO 8'h08
`define ADCSQ_OFS_CTRL_ONE 8'h0c
`define ADCSQ_OFS_BANDGAP 8'h10
`define ADCSQ_OFS_IRQ_STATUS 8'h14
`define ADCSQ_OFS_IRQ_CLEAR 8'h18
`define ADCSQ_OFS_IRQ_ENABLE 8'h1c
`define ADCSQ_BIT_START 7
`define ADCSQ_BIT_BUSY 6
`define ADCSQ_BIT_ENABLE 5
`define ADCSQ_BIT_ALIGN 4
`define ADCSQ_BIT_BANDGAP 3
`define ADCSQ_BIT_IRQ_DONE 0
`define ADCSQ_BIT_IRQ_ABORT 1
`define ADCSQ_RST_CTRL_ZERO 8'h00
`define ADCSQ_RST_CTRL_ONE 8'h00
`define ADCSQ_RST_BANDGAP 1'b0
`define ADCSQ_RST_RESULT 10'h000
`define ADCSQ_RST_IRQ 2'h0
`define ADCSQ_SRC_INTERNAL 3'h4
`define ADCSQ_SAR_MSB 10'h200
`define ADCSQ_SAR_TOP_INDEX 4'h9
`define ADCSQ_RESP_OKAY 2'h0
`define ADCSQ_RESP_SLVERR 2'h2
`endif

// ==== hdl/adcsq_pkg.sv ====
// types shared by the converter sequencer
`default_nettype none
package adcsq_pkg;
    typedef struct packed {
        logic [6:0] ext_channel;
        logic internal;
        logic ground;
    } adcsq_input_sel_type;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcsq_state_type;
endpackage
`default_nettype wire

// ==== bench/adcsq_tb.sv ====
// self-checking bench for the converter sequencer register block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import adcsq_pkg::*;
    // ----------------------------------------
    // signals and design instance
    // ----------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, reference_voltage_select;
    logic [31:0] s_axi_rdata;
    logic [6:0] pin_analog_assign = 7'h00;
    logic clk_en = 1'b1;
    logic [6:0] pin_function_disconnect, pull_high_disable;
    logic comparator_in = 1'b0;
    adcsq_input_sel_type input_sel;
    logic [9:0] dac_code;
    logic [9:0] analog_val = 10'h000;
    logic sample_hold, converter_power, bandgap_enable, irq;
    int err_count = 0;
    int cmp_count = 0;
    int sh_cnt = 0;
    logic [31:0] rd_data;
    logic [1:0] rd_resp, wr_resp;
    logic [8:0] exp_sel;

    always #10 aclk = ~aclk;
    // analog side: comparator answers input >= trial code
    always @(posedge aclk) comparator_in <= (analog_val >= dac_code);
    always @(posedge aclk) if (sample_hold === 1'b1) sh_cnt <= sh_cnt + 1;

    adcsq_regs #(.ADDR_W(8)) DUT (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pin_analog_assign(pin_analog_assign),
        .comparator_in(comparator_in), .pin_function_disconnect(pin_function_disconnect),
        .pull_high_disable(pull_high_disable), .input_sel(input_sel),
        .dac_code(dac_code), .sample_hold(sample_hold),
        .converter_power(converter_power), .bandgap_enable(bandgap_enable),
        .reference_voltage_select(reference_voltage_select), .irq(irq)
    );
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'h1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        rd(a);
        chk(name, exp, rd_data);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        rd(8'h08);
        while (rd_data[6] !== 1'b0 && n < 200) begin
            rd(8'h08);
            n++;
        end
    endtask

    // start pulse 1 then 0 with the converter on, then wait for completion
    task automatic convert(input logic [2:0] div, input logic [9:0] val);
        analog_val = val;
        wr(8'h0c, {5'h00, div});
        wr(8'h08, 8'ha0);
        sh_cnt = 0;
        wr(8'h08, 8'h20);
        rd_chk(8'h08, 32'h60, "busy during conversion");
        chk("converter power", 32'h1, {31'h0, converter_power});
        wait_idle();
        chk("busy after conversion", 32'h20, rd_data);
        chk("sample phase length", 32'h1 << div, sh_cnt);
        rd_chk(8'h04, {24'h0, val[9:2]}, "high byte align 0");
        rd_chk(8'h00, {24'h0, val[1:0], 6'h00}, "low byte align 0");
        wr(8'h08, 8'h30);
        rd_chk(8'h00, {24'h0, val[7:0]}, "low byte align 1");
        rd_chk(8'h04, {30'h0, val[9:8]}, "high byte align 1");
        wr(8'h08, 8'h20);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (40000) @(posedge aclk);
        err_count++;
        $display("BAD watchdog expected done seen hang");
        tally_and_finish();
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(8'h08, 32'h0, "ctrl zero reset");
        rd_chk(8'h0c, 32'h0, "ctrl one reset");
        rd_chk(8'h20, 32'h0, "unmapped read data");
        chk("unmapped read resp", 32'h2, {30'h0, rd_resp});
        wr(8'h24, 8'hff);
        chk("unmapped write resp", 32'h2, {30'h0, wr_resp});
        wr(8'h08, 8'h40);
        rd_chk(8'h08, 32'h0, "busy bit write ignored");
        wr(8'h10, 8'hff);
        rd_chk(8'h10, 32'h08, "bandgap readback");
        chk("bandgap output", 32'h1, {31'h0, bandgap_enable});
        wr(8'h0c, 8'h18);
        @(posedge aclk);
        chk("reference select", 32'h3, {30'h0, reference_voltage_select});
        pin_analog_assign <= 7'h55;
        repeat (3) @(posedge aclk);
        chk("pin disconnect", 32'h55, {25'h0, pin_function_disconnect});
        chk("pull high off", 32'h55, {25'h0, pull_high_disable});
        // clock enable low must freeze the pin flops
        clk_en <= 1'b0;
        pin_analog_assign <= 7'h2a;
        repeat (3) @(posedge aclk);
        chk("pins frozen", 32'h55, {25'h0, pull_high_disable});
        clk_en <= 1'b1;
        pin_analog_assign <= 7'h55;
        wr(8'h0c, 8'h00);
        for (int c = 0; c < 16; c++) begin
            wr(8'h08, 8'h20 | 8'(c));
            repeat (2) @(posedge aclk);
            exp_sel = (c == 0 || (c >= 2 && c <= 6)) ? {7'h01 << c, 2'b00} : 9'h000;
            chk("channel route", {23'h0, exp_sel}, {23'h0, input_sel});
        end
        wr(8'h08, 8'h23);
        for (int s = 0; s < 8; s++) begin
            wr(8'h0c, {3'(s), 5'h00});
            repeat (2) @(posedge aclk);
            exp_sel = (s == 4) ? 9'h002 : (s >= 1 && s <= 3) ? 9'h001 : 9'h020;
            chk("source route", {23'h0, exp_sel}, {23'h0, input_sel});
        end
        wr(8'h08, 8'h03);
        repeat (2) @(posedge aclk);
        chk("route when off", 32'h0, {23'h0, input_sel});
        chk("power when off", 32'h0, {31'h0, converter_power});
        wr(8'h1c, 8'h01);
        convert(3'h3, 10'h2a7);
        rd_chk(8'h14, 32'h1, "done status");
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(8'h18, 8'h01);
        rd_chk(8'h14, 32'h0, "status cleared");
        chk("irq after clear", 32'h0, {31'h0, irq});
        convert(3'h4, 10'h15b);
        wr(8'h1c, 8'h00);
        repeat (2) @(posedge aclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h18, 8'h03);
        wr(8'h1c, 8'h03);
        analog_val = 10'h3ff;
        wr(8'h08, 8'ha0);
        wr(8'h08, 8'h20);
        repeat (20) @(posedge aclk);
        wr(8'h08, 8'h10);
        rd_chk(8'h08, 32'h10, "busy after abort");
        rd_chk(8'h14, 32'h2, "abort status");
        rd_chk(8'h00, 32'h5b, "low byte after abort");
        chk("power after abort", 32'h0, {31'h0, converter_power});
        wr(8'h08, 8'h90);
        wr(8'h08, 8'h10);
        repeat (200) @(posedge aclk);
        rd_chk(8'h08, 32'h10, "no start while off");
        rd_chk(8'h04, 32'h1, "high byte while off");
        rd_chk(8'h00, 32'h5b, "low byte while off");
        tally_and_finish();
    end
endmodule
`default_nettype wire
